//--- hw/inhibit_pkg.sv
package inhibit_pkg;
   // Clock rate and derived seconds tick
   localparam int unsigned CLK_HZ = 200000000;
   localparam int unsigned TICK_CYCLES = CLK_HZ;
   // Fixed delays and timeouts in seconds
   localparam logic [15:0] RUN_OFF_DELAY_S = 16'h0002;
   localparam logic [15:0] COMM_HOLD_S = 16'h001e;
   // Communication-port command codes
   localparam logic [7:0] CMD_BRK_ON_A = 8'h1f;
   localparam logic [7:0] CMD_BRK_ON_B = 8'h20;
   localparam logic [7:0] CMD_BRK_OFF = 8'h21;
   // Event-enable bit for inhibit events
   localparam int unsigned EVT_EN_BIT = 6;
   // Time of day in minutes
   localparam logic [10:0] MIN_PER_DAY = 11'h5a0;
   // Register map of the plain software port
   localparam logic [3:0] ADDR_ON_DELAY = 4'h0;
   localparam logic [3:0] ADDR_OFF_DELAY = 4'h1;
   localparam logic [3:0] ADDR_DAYS = 4'h2;
   localparam logic [3:0] ADDR_WIN_START = 4'h3;
   localparam logic [3:0] ADDR_WIN_STOP = 4'h4;
   localparam logic [3:0] ADDR_MAX_FAIL = 4'h5;
   localparam logic [3:0] ADDR_EVT_EN = 4'h6;
   localparam logic [3:0] ADDR_STATUS = 4'h7;
   // Reset values
   localparam logic [15:0] ON_DELAY_RST = 16'h0000;
   localparam logic [15:0] OFF_DELAY_RST = 16'h0000;
   localparam logic [6:0] DAYS_RST = 7'h7f;
   localparam logic [10:0] WIN_RST = 11'h000;
   localparam logic [15:0] MAX_FAIL_RST = 16'h003c;
   localparam logic [7:0] EVT_EN_RST = 8'h00;
   // Event codes on the event port
   typedef enum logic [3:0] {
      EV_NONE = 4'h0,
      EV_SI_INPUT_ON = 4'h1,
      EV_SI_INPUT_OFF = 4'h2,
      EV_SI_SCHED_ON = 4'h3,
      EV_SI_SCHED_OFF = 4'h4,
      EV_SI_GRID_ON = 4'h5,
      EV_SI_GRID_OFF = 4'h6,
      EV_SI_PEER_ON = 4'h7,
      EV_SI_PEER_OFF = 4'h8,
      EV_BI_INPUT_ON = 4'h9,
      EV_BI_GRID_ON = 4'ha,
      EV_BI_COMM_ON = 4'hb,
      EV_BI_PEER_ON = 4'hc,
      EV_BI_SYNC_ON = 4'hd,
      EV_BI_MASTER_ON = 4'he,
      EV_BI_ALL_CLEAR = 4'hf
   } event_code_e;
endpackage

//--- hw/sec_timer.sv
// Seconds down-counter: loads on start, done when it reaches zero
module sec_timer (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [15:0] secs,
   input wire logic run,
   input wire logic tick,
   output logic done
);
   logic [15:0] cnt_r;
   logic armed_r;

   // ------------------------------------------------------------
   // Count whole seconds while run stays high
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 16'h0000;
         armed_r <= 1'b0;
      end else if (start) begin
         cnt_r <= secs;
         armed_r <= 1'b1;
      end else if (!run) begin
         armed_r <= 1'b0;
      end else if (tick && cnt_r != 16'h0000) begin
         cnt_r <= cnt_r - 16'h0001;
      end
   end

   assign done = armed_r && run && cnt_r == 16'h0000;
endmodule

//--- hw/tick_gen.sv
// One-cycle pulse once per second
module tick_gen
   import inhibit_pkg::*;
#(
   parameter int unsigned PERIOD = TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   output logic tick
);
   logic [31:0] cnt_r;

   // ------------------------------------------------------------
   // Free-running divider
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 32'h00000000;
      end else if (cnt_r == 32'(PERIOD - 1)) begin
         cnt_r <= 32'h00000000;
      end else begin
         cnt_r <= cnt_r + 32'h00000001;
      end
   end

   assign tick = cnt_r == 32'(PERIOD - 1);
endmodule

//--- hw/inhibit_core.sv
// Behaviour
// - Any active start-inhibit input raises the input start request.
// - Input activation waits programmed delay in automatic mode, zero otherwise.
// - Input deactivation waits programmed delay, or two seconds when generator runs.
// - Generic per-input filter delay is not applied to these inputs.
// - Scheduler inhibits outside enabled weekdays or outside enabled time window.
// - Unreliable real-time clock raises the clock-invalid anomaly.
// - Stop above start same day, below start next day, equal means whole day.
// - Load management not needing this engine raises a start request.
// - Parallel-only grid anomaly opens breaker; start request after max failure time.
// - Peer breaker fault: after max failure time raise start request until cleared.
// - Master start request only when every connected master broadcasts one.
// - Start-source on/off events logged only when event-enable bit 6 set.
// - One status flag per start-inhibit source.
// - Any active supply-inhibit input raises the input breaker request.
// - Parallel-only grid anomaly holds breaker request until grid suitable.
// - Port command 31 or 32 sets, 33 clears the port breaker request.
// - Port breaker request drops 30 seconds after last activating command.
// - Peer breaker fault holds breaker request until fault fixed.
// - Grid-breaker sync with own breaker open holds breaker request.
// - Master asking breakers open raises a breaker request.
// - One activation event per breaker source; one common event when all clear.
// - Start inhibition is not acted on in test or remote-start sub-modes.
module inhibit_core
   import inhibit_pkg::*;
#(
   parameter int unsigned N_INPUTS = 8,
   parameter int unsigned N_MASTERS = 4,
   parameter int unsigned TICK_PERIOD = TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [N_INPUTS-1:0] start_inhibit_input_fn,
   input wire logic [N_INPUTS-1:0] supply_inhibit_input_fn,
   input wire logic auto_mode,
   input wire logic test_or_remote_mode,
   input wire logic gen_running,
   input wire logic [2:0] weekday,
   input wire logic [10:0] minute_of_day,
   input wire logic clock_valid,
   input wire logic load_not_needed,
   input wire logic parallel_only_app,
   input wire logic grid_suitable,
   input wire logic peer_breaker_fault,
   input wire logic [N_MASTERS-1:0] master_present,
   input wire logic [N_MASTERS-1:0] master_start_inhibit,
   input wire logic master_open_breakers,
   input wire logic grid_sync_active,
   input wire logic generator_breaker_closed,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   output logic start_inhibit,
   output logic breaker_inhibit,
   output logic open_breaker,
   output logic clock_invalid_anomaly,
   output logic [5:0] start_flags,
   output logic [5:0] breaker_flags,
   output logic event_valid,
   output inhibit_pkg::event_code_e event_code
);
   import inhibit_pkg::*;

   logic tick;
   logic [15:0] on_delay_r, off_delay_r, max_fail_r;
   logic [6:0] days_r;
   logic [10:0] win_start_r, win_stop_r;
   logic [7:0] evt_en_r;
   logic in_raw, in_req_r, on_done, off_done;
   logic sched_req, grid_fail_done, peer_done;
   logic grid_start_r, peer_start_r, comm_req_r, comm_done;
   logic master_req, grid_anom, comm_set;
   logic [5:0] sflag, bflag, sflag_d_r, bflag_d_r;
   logic [15:0] on_secs, off_secs;
   logic u_on_run_r, u_off_run_r, grid_armed_r, peer_armed_r;

   // ------------------------------------------------------------
   // Seconds tick and delay timers
   // ------------------------------------------------------------
   tick_gen #(.PERIOD(TICK_PERIOD)) u_tick (
      .core_clk(core_clk),
      .rst(rst),
      .tick(tick)
   );

   // Raw inputs only; no generic per-input filter on this path
   assign in_raw = |start_inhibit_input_fn;
   assign on_secs = auto_mode ? on_delay_r : 16'h0000;
   assign off_secs = gen_running ? RUN_OFF_DELAY_S : off_delay_r;

   sec_timer u_on (
      .core_clk(core_clk),
      .rst(rst),
      .start(in_raw && !in_req_r && !u_on_run_r),
      .secs(on_secs),
      .run(in_raw && !in_req_r),
      .tick(tick),
      .done(on_done)
   );

   sec_timer u_off (
      .core_clk(core_clk),
      .rst(rst),
      .start(!in_raw && in_req_r && !u_off_run_r),
      .secs(off_secs),
      .run(!in_raw && in_req_r),
      .tick(tick),
      .done(off_done)
   );

   // Tracks whether each delay is already counting
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         u_on_run_r <= 1'b0;
         u_off_run_r <= 1'b0;
      end else begin
         u_on_run_r <= in_raw && !in_req_r;
         u_off_run_r <= !in_raw && in_req_r;
      end
   end

   // Logical input request after activation/deactivation delays
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         in_req_r <= 1'b0;
      end else if (on_done) begin
         in_req_r <= 1'b1;
      end else if (off_done) begin
         in_req_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Scheduler window
   // ------------------------------------------------------------
   function automatic logic in_window(input logic [10:0] t, input logic [10:0] a,
                                      input logic [10:0] b);
      if (a == b) begin
         in_window = 1'b1;
      end else if (b > a) begin
         in_window = t >= a && t < b;
      end else begin
         in_window = t >= a || t < b;
      end
   endfunction

   // Day check follows the start day for windows running past midnight
   logic [2:0] start_day;
   logic day_ok;
   assign start_day = (win_stop_r < win_start_r && minute_of_day < win_stop_r)
                      ? ((weekday == 3'h0) ? 3'h6 : weekday - 3'h1) : weekday;
   assign day_ok = days_r[start_day];
   assign sched_req = !day_ok || !in_window(minute_of_day, win_start_r, win_stop_r);
   assign clock_invalid_anomaly = !clock_valid;

   // ------------------------------------------------------------
   // Grid conditions and peer breaker fault
   // ------------------------------------------------------------
   assign grid_anom = parallel_only_app && !grid_suitable;
   assign open_breaker = grid_anom || peer_breaker_fault || master_open_breakers;

   sec_timer u_grid (
      .core_clk(core_clk),
      .rst(rst),
      .start(grid_anom && !grid_armed_r),
      .secs(max_fail_r),
      .run(grid_anom),
      .tick(tick),
      .done(grid_fail_done)
   );

   sec_timer u_peer (
      .core_clk(core_clk),
      .rst(rst),
      .start(peer_breaker_fault && !peer_armed_r),
      .secs(max_fail_r),
      .run(peer_breaker_fault),
      .tick(tick),
      .done(peer_done)
   );

   // Start requests after the max failure time, dropped when cleared
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         grid_armed_r <= 1'b0;
         peer_armed_r <= 1'b0;
         grid_start_r <= 1'b0;
         peer_start_r <= 1'b0;
      end else begin
         grid_armed_r <= grid_anom;
         peer_armed_r <= peer_breaker_fault;
         grid_start_r <= grid_anom && (grid_start_r || grid_fail_done);
         peer_start_r <= peer_breaker_fault && (peer_start_r || peer_done);
      end
   end

   // ------------------------------------------------------------
   // Master broadcasts and communication-port command
   // ------------------------------------------------------------
   assign master_req = (|master_present)
                       && ((master_present & ~master_start_inhibit) == '0);

   assign comm_set = cmd_valid && (cmd_code == CMD_BRK_ON_A || cmd_code == CMD_BRK_ON_B);

   sec_timer u_comm (
      .core_clk(core_clk),
      .rst(rst),
      .start(comm_set),
      .secs(COMM_HOLD_S),
      .run(comm_req_r || comm_set),
      .tick(tick),
      .done(comm_done)
   );

   // Port request: set by 31/32, cleared by 33 or by the hold timeout
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         comm_req_r <= 1'b0;
      end else if (comm_set) begin
         comm_req_r <= 1'b1;
      end else if (cmd_valid && cmd_code == CMD_BRK_OFF) begin
         comm_req_r <= 1'b0;
      end else if (comm_done) begin
         comm_req_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Source flags and outputs
   // ------------------------------------------------------------
   // Start flags: input, scheduler, load, grid, peer, master
   assign sflag = {master_req, peer_start_r, grid_start_r, load_not_needed, sched_req,
                   in_req_r};
   // Breaker flags: input, grid, port, peer, sync, master
   assign bflag = {master_open_breakers,
                   grid_sync_active && !generator_breaker_closed,
                   peer_breaker_fault,
                   comm_req_r,
                   grid_anom,
                   |supply_inhibit_input_fn};
   assign start_flags = sflag;
   assign breaker_flags = bflag;
   assign start_inhibit = (|sflag) && !test_or_remote_mode;
   assign breaker_inhibit = |bflag;

   // ------------------------------------------------------------
   // Event log, one event per cycle by fixed priority
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sflag_d_r <= 6'h00;
         bflag_d_r <= 6'h00;
      end else begin
         sflag_d_r <= sflag;
         bflag_d_r <= bflag;
      end
   end

   event_code_e ev_nxt;
   logic [5:0] s_on, s_off, b_on;
   assign s_on = sflag & ~sflag_d_r;
   assign s_off = ~sflag & sflag_d_r;
   assign b_on = bflag & ~bflag_d_r;

   always_comb begin
      ev_nxt = EV_NONE;
      if (evt_en_r[EVT_EN_BIT]) begin
         if (s_on[0]) ev_nxt = EV_SI_INPUT_ON;
         else if (s_off[0]) ev_nxt = EV_SI_INPUT_OFF;
         else if (s_on[1]) ev_nxt = EV_SI_SCHED_ON;
         else if (s_off[1]) ev_nxt = EV_SI_SCHED_OFF;
         else if (s_on[3]) ev_nxt = EV_SI_GRID_ON;
         else if (s_off[3]) ev_nxt = EV_SI_GRID_OFF;
         else if (s_on[4]) ev_nxt = EV_SI_PEER_ON;
         else if (s_off[4]) ev_nxt = EV_SI_PEER_OFF;
         else if (b_on[0]) ev_nxt = EV_BI_INPUT_ON;
         else if (b_on[1]) ev_nxt = EV_BI_GRID_ON;
         else if (b_on[2]) ev_nxt = EV_BI_COMM_ON;
         else if (b_on[3]) ev_nxt = EV_BI_PEER_ON;
         else if (b_on[4]) ev_nxt = EV_BI_SYNC_ON;
         else if (b_on[5]) ev_nxt = EV_BI_MASTER_ON;
         else if (bflag == 6'h00 && bflag_d_r != 6'h00) ev_nxt = EV_BI_ALL_CLEAR;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         event_valid <= 1'b0;
         event_code <= EV_NONE;
      end else begin
         event_valid <= ev_nxt != EV_NONE;
         event_code <= ev_nxt;
      end
   end

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         on_delay_r <= ON_DELAY_RST;
         off_delay_r <= OFF_DELAY_RST;
         days_r <= DAYS_RST;
         win_start_r <= WIN_RST;
         win_stop_r <= WIN_RST;
         max_fail_r <= MAX_FAIL_RST;
         evt_en_r <= EVT_EN_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_ON_DELAY: on_delay_r <= reg_wdata;
            ADDR_OFF_DELAY: off_delay_r <= reg_wdata;
            ADDR_DAYS: days_r <= reg_wdata[6:0];
            ADDR_WIN_START: win_start_r <= reg_wdata[10:0];
            ADDR_WIN_STOP: win_stop_r <= reg_wdata[10:0];
            ADDR_MAX_FAIL: max_fail_r <= reg_wdata;
            ADDR_EVT_EN: evt_en_r <= reg_wdata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_ON_DELAY: reg_rdata <= on_delay_r;
            ADDR_OFF_DELAY: reg_rdata <= off_delay_r;
            ADDR_DAYS: reg_rdata <= {9'h000, days_r};
            ADDR_WIN_START: reg_rdata <= {5'h00, win_start_r};
            ADDR_WIN_STOP: reg_rdata <= {5'h00, win_stop_r};
            ADDR_MAX_FAIL: reg_rdata <= max_fail_r;
            ADDR_EVT_EN: reg_rdata <= {8'h00, evt_en_r};
            ADDR_STATUS: reg_rdata <= {2'h0, bflag, sflag, 1'b0, clock_invalid_anomaly};
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   grid_open_a: assert property (@(posedge core_clk) disable iff (rst)
      grid_anom |-> open_breaker && breaker_flags[1]) else $error("grid anomaly no open");
   mode_mask_a: assert property (@(posedge core_clk) disable iff (rst)
      test_or_remote_mode |-> !start_inhibit) else $error("inhibit in test mode");
   port_off_a: assert property (@(posedge core_clk) disable iff (rst)
      cmd_valid && cmd_code == CMD_BRK_OFF |=> !comm_req_r) else $error("port off");
   port_on_a: assert property (@(posedge core_clk) disable iff (rst)
      comm_set |=> comm_req_r) else $error("port on");
   master_all_a: assert property (@(posedge core_clk) disable iff (rst)
      (master_present & ~master_start_inhibit) != '0 |-> !start_flags[5])
      else $error("master partial");
   evt_gate_a: assert property (@(posedge core_clk) disable iff (rst)
      !evt_en_r[EVT_EN_BIT] |=> !event_valid) else $error("event while disabled");
   sync_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      grid_sync_active && !generator_breaker_closed |-> breaker_inhibit)
      else $error("sync no inhibit");
   input_now_a: assert property (@(posedge core_clk) disable iff (rst)
      !auto_mode && in_raw && !in_req_r ##1 in_raw [*3] |-> in_req_r)
      else $error("zero delay missed");
endmodule

//--- dv/can_peers.sv
// ------------------------------------------------------------
// Peer genset and master controllers on the parallel bus
// ------------------------------------------------------------
module can_peers #(
   parameter int unsigned N_MASTERS = 3
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] lag,
   input wire logic [N_MASTERS-1:0] req_present,
   input wire logic [N_MASTERS-1:0] req_inhibit,
   input wire logic req_open,
   input wire logic req_fault,
   input wire logic req_sync,
   output logic [N_MASTERS-1:0] master_present,
   output logic [N_MASTERS-1:0] master_start_inhibit,
   output logic master_open_breakers,
   output logic peer_breaker_fault,
   output logic grid_sync_active
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_r;
   logic differs;
   // Pending broadcast differs from what the bus shows
   assign differs = {req_present, req_inhibit, req_open, req_fault, req_sync} !==
      {master_present, master_start_inhibit, master_open_breakers, peer_breaker_fault,
       grid_sync_active};
   // Broadcasts reach the bus after a prompt or slow lag
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wait_r <= 4'h0;
         master_present <= '0;
         master_start_inhibit <= '0;
         master_open_breakers <= 1'b0;
         peer_breaker_fault <= 1'b0;
         grid_sync_active <= 1'b0;
      end else if (!differs) begin
         wait_r <= 4'h0;
      end else if (wait_r >= lag) begin
         wait_r <= 4'h0;
         master_present <= req_present;
         master_start_inhibit <= req_inhibit;
         master_open_breakers <= req_open;
         peer_breaker_fault <= req_fault;
         grid_sync_active <= req_sync;
      end else begin
         wait_r <= wait_r + 4'h1;
      end
   end
endmodule

//--- dv/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import inhibit_pkg::*;
   localparam int NI = 4;
   localparam int NM = 3;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0, reg_rd = 1'b0, cmd_valid = 1'b0;
   logic [15:0] reg_rdata;
   logic [NI-1:0] si_fn = '0, bi_fn = '0;
   logic auto_mode = 1'b0, tr_mode = 1'b0, gen_run = 1'b0, clk_ok = 1'b0, load_nn = 1'b0;
   logic par_only = 1'b0, grid_ok = 1'b1, gb_closed = 1'b0;
   logic [2:0] weekday = 3'h0;
   logic [10:0] minute = 11'h000;
   logic [7:0] cmd_code = 8'h00;
   logic [NM-1:0] m_pres, m_inh, r_pres = '0, r_inh = '0;
   logic m_open, p_fault, g_sync, r_open = 1'b0, r_fault = 1'b0, r_sync = 1'b0;
   logic [3:0] lag = 4'h0;
   logic si, bi, ob, cia, ev_v;
   logic [5:0] sf, bf;
   event_code_e ev_c;
   event_code_e ev_q[$];
   int bad_count = 0;
   int checks_done = 0;
   // Clock source
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   inhibit_core #(.N_INPUTS(NI), .N_MASTERS(NM), .TICK_PERIOD(10)) dut (.core_clk(core_clk),
      .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .start_inhibit_input_fn(si_fn), .supply_inhibit_input_fn(bi_fn),
      .auto_mode(auto_mode), .test_or_remote_mode(tr_mode), .gen_running(gen_run),
      .weekday(weekday), .minute_of_day(minute), .clock_valid(clk_ok), .load_not_needed(load_nn),
      .parallel_only_app(par_only), .grid_suitable(grid_ok), .peer_breaker_fault(p_fault),
      .master_present(m_pres), .master_start_inhibit(m_inh), .master_open_breakers(m_open),
      .grid_sync_active(g_sync), .generator_breaker_closed(gb_closed), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .start_inhibit(si), .breaker_inhibit(bi), .open_breaker(ob),
      .clock_invalid_anomaly(cia), .start_flags(sf), .breaker_flags(bf), .event_valid(ev_v),
      .event_code(ev_c));
   can_peers #(.N_MASTERS(NM)) peers (.core_clk(core_clk), .rst(rst), .lag(lag),
      .req_present(r_pres), .req_inhibit(r_inh), .req_open(r_open), .req_fault(r_fault),
      .req_sync(r_sync), .master_present(m_pres), .master_start_inhibit(m_inh),
      .master_open_breakers(m_open), .peer_breaker_fault(p_fault), .grid_sync_active(g_sync));
   // Event log
   always @(posedge core_clk) begin
      if (ev_v === 1'b1) ev_q.push_back(ev_c);
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_ev(event_code_e exp, bit want);
      bit hit;
      hit = 1'b0;
      @(negedge core_clk);
      foreach (ev_q[i]) if (ev_q[i] === exp) hit = 1'b1;
      checks_done++;
      if (hit != want) begin
         bad_count++;
         $display("wrong value at %0t: event %h seen %0d", $time, exp, hit);
      end
      ev_q.delete();
   endtask
   task automatic look(int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
      chk(16'(si), 16'(!tr_mode && (|sf)));
      chk(16'(bi), 16'(|bf));
   endtask
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [15:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk(reg_rdata, exp);
   endtask
   task automatic cmd(logic [7:0] c);
      @(posedge core_clk);
      cmd_code <= c;
      cmd_valid <= 1'b1;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
   endtask
   function automatic logic sched_f(logic [6:0] d, logic [2:0] wd, logic [10:0] m,
                                    logic [10:0] a, logic [10:0] b);
      logic prev;
      prev = d[(wd == 3'd0) ? 3'd6 : wd - 3'd1];
      if (a == b) return !d[wd];
      if (b > a) return !(d[wd] && m >= a && m < b);
      return !((d[wd] && m >= a) || (prev && m < b));
   endfunction
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      conclude;
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      logic [6:0] dd;
      logic [10:0] a;
      logic [10:0] b;
      void'($urandom(32'h23f3));
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rd(ADDR_DAYS, 16'(DAYS_RST));
      rd(ADDR_MAX_FAIL, MAX_FAIL_RST);
      wr(ADDR_STATUS, 16'hffff);
      wr(4'h9, 16'h1234);
      rd(4'h9, 16'h0000);
      rd(ADDR_STATUS, 16'h0001);
      wr(ADDR_MAX_FAIL, 16'h0003);
      wr(ADDR_EVT_EN, 16'h0040);
      wr(ADDR_ON_DELAY, 16'h0003);
      wr(ADDR_OFF_DELAY, 16'h0005);
      clk_ok <= 1'b1;
      si_fn <= NI'($urandom_range(1, 15));
      look(3);
      chk(16'(cia), 16'h0);
      chk(16'(sf[0]), 16'h1);
      chk_ev(EV_SI_INPUT_ON, 1'b1);
      @(posedge core_clk);
      gen_run <= 1'b1;
      si_fn <= '0;
      look(5);
      chk(16'(sf[0]), 16'h1);
      look(25);
      chk(16'(sf[0]), 16'h0);
      @(posedge core_clk);
      gen_run <= 1'b0;
      auto_mode <= 1'b1;
      si_fn <= NI'($urandom_range(1, 15));
      look(15);
      chk(16'(sf[0]), 16'h0);
      @(posedge core_clk);
      tr_mode <= 1'b1;
      look(25);
      chk(16'(sf[0]), 16'h1);
      @(posedge core_clk);
      tr_mode <= 1'b0;
      si_fn <= '0;
      look(35);
      chk(16'(sf[0]), 16'h1);
      look(25);
      chk(16'(sf[0]), 16'h0);
      @(posedge core_clk);
      bi_fn <= NI'($urandom_range(1, 15));
      load_nn <= 1'b1;
      look(3);
      chk(16'(bf[0]), 16'h1);
      chk(16'(sf[2]), 16'h1);
      chk_ev(EV_BI_INPUT_ON, 1'b1);
      @(posedge core_clk);
      bi_fn <= '0;
      load_nn <= 1'b0;
      look(3);
      chk_ev(EV_BI_ALL_CLEAR, 1'b1);
      for (int i = 0; i < 16; i++) begin
         dd = 7'($urandom);
         a = 11'($urandom_range(0, 1439));
         b = (i % 4 == 0) ? a : 11'($urandom_range(0, 1439));
         wr(ADDR_DAYS, 16'(dd));
         wr(ADDR_WIN_START, 16'(a));
         wr(ADDR_WIN_STOP, 16'(b));
         @(posedge core_clk);
         weekday <= 3'($urandom_range(0, 6));
         minute <= 11'($urandom_range(0, 1439));
         look(2);
         chk(16'(sf[1]), 16'(sched_f(dd, weekday, minute, a, b)));
      end
      wr(ADDR_DAYS, 16'h007f);
      wr(ADDR_WIN_STOP, 16'(a));
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         r_pres <= NM'($urandom);
         r_inh <= (i % 2 == 0) ? {NM{1'b1}} : NM'($urandom);
         lag <= 4'($urandom_range(0, 7));
         look(12);
         chk(16'(sf[5]), 16'((r_pres != 0) && ((r_inh & r_pres) == r_pres)));
      end
      @(posedge core_clk);
      r_pres <= '0;
      r_open <= 1'b1;
      r_sync <= 1'b1;
      look(12);
      chk(16'(bf[5]), 16'h1);
      chk(16'(bf[4]), 16'h1);
      @(posedge core_clk);
      r_open <= 1'b0;
      gb_closed <= 1'b1;
      look(12);
      chk(16'(bf[4]), 16'h0);
      @(posedge core_clk);
      r_sync <= 1'b0;
      r_fault <= 1'b1;
      look(12);
      chk(16'(bf[3]), 16'h1);
      chk(16'(sf[4]), 16'h0);
      look(40);
      chk(16'(sf[4]), 16'h1);
      @(posedge core_clk);
      r_fault <= 1'b0;
      par_only <= 1'b1;
      grid_ok <= 1'b0;
      look(12);
      chk(16'({ob, bf[3], bf[1], sf[4], sf[3]}), 16'h14);
      look(40);
      chk(16'(sf[3]), 16'h1);
      chk_ev(EV_SI_GRID_ON, 1'b1);
      @(posedge core_clk);
      grid_ok <= 1'b1;
      look(3);
      chk(16'({ob, bf[1], sf[3]}), 16'h0);
      cmd(CMD_BRK_ON_A);
      look(1);
      chk(16'(bf[2]), 16'h1);
      cmd(CMD_BRK_OFF);
      look(1);
      chk(16'(bf[2]), 16'h0);
      cmd(CMD_BRK_ON_B);
      look(250);
      cmd(CMD_BRK_ON_A);
      look(150);
      chk(16'(bf[2]), 16'h1);
      look(170);
      chk(16'(bf[2]), 16'h0);
      wr(ADDR_EVT_EN, 16'h0000);
      ev_q.delete();
      bi_fn <= NI'(1);
      look(3);
      chk_ev(EV_BI_INPUT_ON, 1'b0);
      conclude;
   end
endmodule
